// file: hdl/i2cs_slave_port.sv
// Two-wire slave port that reads and writes the device's 8-bit registers.
//
// Operation
// - Answer only bus address 0x15.
// - Address bit zero: one reads, zero writes.
// - Work with serial clock up to 400kHz.
// - Sample data on serial clock rising edge.
// - Data change while clock high is START/STOP.
// - Release both lines when bus idle.
// - Acknowledge register address only if register exists.
// - Single write: address, register, data, acknowledges.
// - Advance pointer after each written byte.
// - Burst write repeats data plus acknowledge.
// - Master ends write with STOP or restart.
// - Single read: pointer write, restart, one byte.
// - Keep sending while master acknowledges bytes.
// - Acknowledge held low over ninth clock high.
// - Not-acknowledge ends the transfer.
`timescale 1ns/1ps
module i2cs_slave_port (
	input  wire logic       clock_i,
	input  wire logic       srst_i,
	input  wire logic       link_clk_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	output logic [7:0]      reg_addr_o,
	output logic [7:0]      reg_wdata_o,
	input  wire logic [7:0] reg_rdata_i
);

	// Link-domain reset chain.
	logic                  lrst_meta_reg;
	logic                  lrst_reg;

	// Pin synchronisers and edge history.
	logic                  scl_meta_reg;
	logic                  scl_sync_reg;
	logic                  scl_prev_reg;
	logic                  sda_meta_reg;
	logic                  sda_sync_reg;
	logic                  sda_prev_reg;

	// Decoded bus events.
	logic                  scl_rise;
	logic                  scl_fall;
	logic                  start_det;
	logic                  stop_det;

	// Sequencer state.
	i2cs_pkg::i2cs_state_t st_reg;
	i2cs_pkg::i2cs_state_t st_next;
	logic [3:0]            cnt_reg;
	logic [3:0]            cnt_next;
	logic [7:0]            rx_reg;
	logic [7:0]            rx_next;
	logic [7:0]            tx_reg;
	logic [7:0]            tx_next;
	logic [7:0]            ptr_reg;
	logic [7:0]            ptr_next;
	logic                  rw_reg;
	logic                  rw_next;
	logic                  drv_reg;
	logic                  drv_next;
	logic                  more_reg;
	logic                  more_next;

	// Named decodes used by the sequencer.
	logic                  byte_done;
	logic                  addr_hit;
	logic                  reg_ok;
	logic [7:0]            ptr_inc;
	logic [3:0]            cnt_inc;
	logic [7:0]            tx_shift;
	logic [7:0]            rsp_data;

	// Requests toward the core domain.
	logic                  req_valid;
	i2cs_pkg::i2cs_req_t   req_data;
	logic                  core_valid;
	i2cs_pkg::i2cs_req_t   core_req;
	logic                  core_done;
	logic                  core_wr;
	logic                  core_rd;
	logic [7:0]            rsp_raw;
	logic                  rsp_done;
	logic [7:0]            rsp_hold_reg;

	// The link logic needs its own reset, brought over by two flops.
	always_ff @(posedge link_clk_i) begin
		lrst_meta_reg <= srst_i;
		lrst_reg      <= lrst_meta_reg;
	end

	// Both bus lines pass two flops plus a history flop; the second and third stages are looked at.
	always_ff @(posedge link_clk_i) begin
		if (lrst_reg) begin
			scl_meta_reg <= 1'b1;
			scl_sync_reg <= 1'b1;
			scl_prev_reg <= 1'b1;
			sda_meta_reg <= 1'b1;
			sda_sync_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_meta_reg <= scl_i;
			scl_sync_reg <= scl_meta_reg;
			scl_prev_reg <= scl_sync_reg;
			sda_meta_reg <= sda_i;
			sda_sync_reg <= sda_meta_reg;
			sda_prev_reg <= sda_sync_reg;
		end
	end

	// Oversampling on the link clock gives dozens of samples per clock phase
	// at the fastest legal bus rate, so no phase can slip past unseen.
	assign scl_rise  = scl_sync_reg & ~scl_prev_reg;
	assign scl_fall  = ~scl_sync_reg & scl_prev_reg;

	// A data edge inside a steady clock-high phase is a bus condition.
	assign start_det = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
	assign stop_det  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

	// Byte-level decodes.
	assign byte_done = cnt_reg == i2cs_pkg::BITS_PER_BYTE;
	assign addr_hit  = rx_reg[7:1] == i2cs_pkg::DEV_ADDR;
	assign reg_ok    = i2cs_pkg::i2cs_reg_exists(rx_reg);
	assign ptr_inc   = 8'(ptr_reg + i2cs_pkg::PTR_STEP);
	assign cnt_inc   = 4'(cnt_reg + 4'h1);
	assign tx_shift  = {tx_reg[6:0], 1'b0};

	// Sequencer: bus conditions first, then rising-edge sampling, then
	// falling-edge actions, since the line may only change while clock is low.
	always_comb begin
		st_next   = st_reg;
		cnt_next  = cnt_reg;
		rx_next   = rx_reg;
		tx_next   = tx_reg;
		ptr_next  = ptr_reg;
		rw_next   = rw_reg;
		drv_next  = drv_reg;
		more_next = more_reg;
		req_valid = 1'b0;
		req_data  = '{wr: 1'b0, addr: ptr_reg, wdata: rx_reg};
		if (stop_det) begin
			st_next  = i2cs_pkg::ST_IDLE;
			drv_next = 1'b0;
		end else if (start_det) begin
			st_next  = i2cs_pkg::ST_DEV_ADR;
			cnt_next = '0;
			drv_next = 1'b0;
		end else if (scl_rise) begin
			if (i2cs_pkg::i2cs_in_byte(st_reg) && !byte_done) begin
				rx_next  = {rx_reg[6:0], sda_sync_reg};
				cnt_next = cnt_inc;
			end
			if (st_reg == i2cs_pkg::ST_RD_ACK) begin
				more_next = ~sda_sync_reg;
				req_valid = ~sda_sync_reg;
			end
		end else if (scl_fall) begin
			unique case (st_reg)
				i2cs_pkg::ST_IDLE: begin
					drv_next = 1'b0;
				end
				i2cs_pkg::ST_DEV_ADR: begin
					if (byte_done) begin
						if (addr_hit) begin
							st_next   = i2cs_pkg::ST_DEV_ACK;
							drv_next  = 1'b1;
							rw_next   = rx_reg[0];
							req_valid = rx_reg[0] == i2cs_pkg::DIR_READ;
						end else begin
							st_next = i2cs_pkg::ST_IDLE;
						end
					end
				end
				i2cs_pkg::ST_DEV_ACK: begin
					cnt_next = '0;
					if (rw_reg == i2cs_pkg::DIR_READ) begin
						st_next  = i2cs_pkg::ST_RD_DATA;
						tx_next  = rsp_data;
						drv_next = ~rsp_data[7];
					end else begin
						st_next  = i2cs_pkg::ST_REG_ADR;
						drv_next = 1'b0;
					end
				end
				i2cs_pkg::ST_REG_ADR: begin
					if (byte_done) begin
						ptr_next = rx_reg;
						st_next  = reg_ok ? i2cs_pkg::ST_REG_ACK : i2cs_pkg::ST_IDLE;
						drv_next = reg_ok;
					end
				end
				i2cs_pkg::ST_REG_ACK: begin
					st_next  = i2cs_pkg::ST_WR_DATA;
					cnt_next = '0;
					drv_next = 1'b0;
				end
				i2cs_pkg::ST_WR_DATA: begin
					if (byte_done) begin
						req_valid = 1'b1;
						req_data  = '{wr: 1'b1, addr: ptr_reg, wdata: rx_reg};
						ptr_next  = ptr_inc;
						st_next   = i2cs_pkg::ST_WR_ACK;
						drv_next  = 1'b1;
					end
				end
				i2cs_pkg::ST_WR_ACK: begin
					st_next  = i2cs_pkg::ST_WR_DATA;
					cnt_next = '0;
					drv_next = 1'b0;
				end
				i2cs_pkg::ST_RD_DATA: begin
					if (byte_done) begin
						st_next  = i2cs_pkg::ST_RD_ACK;
						ptr_next = ptr_inc;
						drv_next = 1'b0;
					end else begin
						tx_next  = tx_shift;
						drv_next = ~tx_shift[7];
					end
				end
				i2cs_pkg::ST_RD_ACK: begin
					cnt_next = '0;
					if (more_reg) begin
						st_next  = i2cs_pkg::ST_RD_DATA;
						tx_next  = rsp_data;
						drv_next = ~rsp_data[7];
					end else begin
						st_next  = i2cs_pkg::ST_IDLE;
						drv_next = 1'b0;
					end
				end
				default: begin
					st_next  = i2cs_pkg::ST_IDLE;
					drv_next = 1'b0;
				end
			endcase
		end
	end

	// Sequencer state flops.
	always_ff @(posedge link_clk_i) begin
		if (lrst_reg) begin
			st_reg   <= i2cs_pkg::ST_IDLE;
			cnt_reg  <= '0;
			rw_reg   <= 1'b0;
			more_reg <= 1'b0;
		end else begin
			st_reg   <= st_next;
			cnt_reg  <= cnt_next;
			rw_reg   <= rw_next;
			more_reg <= more_next;
		end
	end

	// Shift registers and pointer.
	always_ff @(posedge link_clk_i) begin
		if (lrst_reg) begin
			rx_reg  <= '0;
			tx_reg  <= '0;
			ptr_reg <= '0;
		end else begin
			rx_reg  <= rx_next;
			tx_reg  <= tx_next;
			ptr_reg <= ptr_next;
		end
	end

	// Pull-down enable; the line is released out of reset and at every bus condition.
	always_ff @(posedge link_clk_i) begin
		if (lrst_reg) begin
			drv_reg <= 1'b0;
		end else begin
			drv_reg <= drv_next;
		end
	end

	// Open-drain pad: only a low is ever driven.
	assign sda_o    = 1'b0;
	assign sda_oe_o = drv_reg;

	// Accesses cross to the core clock by toggle handshake. Reads are only
	// issued once the master commits to a byte, so read side effects in the
	// register file never fire for a byte that is not taken.
	i2cs_hs_sync u_hs_sync (
		.src_clk_i   (link_clk_i),
		.src_rst_i   (lrst_reg),
		.src_valid_i (req_valid),
		.src_req_i   (req_data),
		.src_busy_o  (),
		.src_done_o  (rsp_done),
		.src_rdata_o (rsp_raw),
		.dst_clk_i   (clock_i),
		.dst_rst_i   (srst_i),
		.dst_valid_o (core_valid),
		.dst_req_o   (core_req),
		.dst_done_i  (core_done),
		.dst_rdata_i (reg_rdata_i)
	);

	// Read data is caught in the link domain only once the returning toggle has been
	// synchronised, so the shifter never loads a word that is still crossing.
	always_ff @(posedge link_clk_i) begin
		if (lrst_reg) begin
			rsp_hold_reg <= '0;
		end else if (rsp_done) begin
			rsp_hold_reg <= rsp_raw;
		end
	end
	assign rsp_data = rsp_hold_reg;

	// Strobe decodes; write data only moves with a write, so a read never
	// disturbs what the register file last saw on the data lines.
	assign core_wr = core_valid & core_req.wr;
	assign core_rd = core_valid & ~core_req.wr;

	// Core side: one-cycle strobes toward the register file; read data is
	// taken in the same cycle as the read strobe.
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			reg_wr_o    <= 1'b0;
			reg_rd_o    <= 1'b0;
			reg_addr_o  <= '0;
			reg_wdata_o <= '0;
		end else begin
			reg_wr_o <= core_wr;
			reg_rd_o <= core_rd;
			if (core_valid) begin
				reg_addr_o <= core_req.addr;
			end
			if (core_wr) begin
				reg_wdata_o <= core_req.wdata;
			end
		end
	end

	// The answer goes back once the strobe has been presented.
	assign core_done = reg_wr_o | reg_rd_o;

endmodule // i2cs_slave_port

// file: pkg/i2cs_pkg.sv
// Shared constants, types and helpers for the two-wire register slave port.
package i2cs_pkg;

	// Seven-bit bus address; with the direction bit it forms 0x2A (write) and 0x2B (read).
	localparam logic [6:0] DEV_ADDR      = 7'h15;
	// Registers 0x00 to 0x0C exist; any register address byte at or above this count is refused.
	localparam logic [7:0] REG_COUNT     = 8'h0D;
	// Data bits in one byte before the acknowledge slot.
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// Step of the register pointer after each byte moved in a burst.
	localparam logic [7:0] PTR_STEP      = 8'h01;
	// Direction bit values carried in the address byte.
	localparam logic       DIR_READ      = 1'b1;

	// Link-side sequencer states.
	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0000,
		ST_DEV_ADR = 4'b0001,
		ST_DEV_ACK = 4'b0010,
		ST_REG_ADR = 4'b0011,
		ST_REG_ACK = 4'b0100,
		ST_WR_DATA = 4'b0101,
		ST_WR_ACK  = 4'b0110,
		ST_RD_DATA = 4'b0111,
		ST_RD_ACK  = 4'b1000
	} i2cs_state_t;

	// One register access handed from the link domain to the core domain.
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} i2cs_req_t;

	// True when a pointer names an existing register.
	function automatic logic i2cs_reg_exists(input logic [7:0] addr);
		return addr < REG_COUNT;
	endfunction

	// True while the sequencer counts bits of a byte on the wire.
	function automatic logic i2cs_in_byte(input i2cs_state_t st);
		return (st == ST_DEV_ADR) || (st == ST_REG_ADR) || (st == ST_WR_DATA) ||
			(st == ST_RD_DATA);
	endfunction

endpackage

// file: hdl/i2cs_hs_sync.sv
// Toggle handshake that carries one access request across clocks and its read data back.
`timescale 1ns/1ps
module i2cs_hs_sync (
	input  wire logic                src_clk_i,
	input  wire logic                src_rst_i,
	input  wire logic                src_valid_i,
	input  wire i2cs_pkg::i2cs_req_t src_req_i,
	output logic                     src_busy_o,
	output logic                     src_done_o,
	output logic [7:0]               src_rdata_o,
	input  wire logic                dst_clk_i,
	input  wire logic                dst_rst_i,
	output logic                     dst_valid_o,
	output i2cs_pkg::i2cs_req_t      dst_req_o,
	input  wire logic                dst_done_i,
	input  wire logic [7:0]          dst_rdata_i
);

	logic                req_tog_reg;
	i2cs_pkg::i2cs_req_t req_data_reg;
	logic                ack_meta_reg;
	logic                ack_sync_reg;
	logic                ack_prev_reg;
	logic                req_meta_reg;
	logic                req_sync_reg;
	logic                req_prev_reg;
	logic                ack_tog_reg;
	logic [7:0]          rdata_reg;
	logic                launch;

	// A new request is only taken while the previous one has been answered.
	assign launch      = src_valid_i & ~src_busy_o;
	assign src_busy_o  = req_tog_reg ^ ack_sync_reg;
	assign src_done_o  = ack_sync_reg ^ ack_prev_reg;
	assign src_rdata_o = rdata_reg;

	// Source side: the payload is held still until the answer returns.
	always_ff @(posedge src_clk_i) begin
		if (src_rst_i) begin
			req_tog_reg  <= 1'b0;
			req_data_reg <= '0;
		end else if (launch) begin
			req_tog_reg  <= ~req_tog_reg;
			req_data_reg <= src_req_i;
		end
	end

	// Source side synchroniser for the returning toggle.
	always_ff @(posedge src_clk_i) begin
		if (src_rst_i) begin
			ack_meta_reg <= 1'b0;
			ack_sync_reg <= 1'b0;
			ack_prev_reg <= 1'b0;
		end else begin
			ack_meta_reg <= ack_tog_reg;
			ack_sync_reg <= ack_meta_reg;
			ack_prev_reg <= ack_sync_reg;
		end
	end

	// Destination side synchroniser; the payload is stable once the toggle is seen.
	always_ff @(posedge dst_clk_i) begin
		if (dst_rst_i) begin
			req_meta_reg <= 1'b0;
			req_sync_reg <= 1'b0;
			req_prev_reg <= 1'b0;
		end else begin
			req_meta_reg <= req_tog_reg;
			req_sync_reg <= req_meta_reg;
			req_prev_reg <= req_sync_reg;
		end
	end

	assign dst_valid_o = req_sync_reg ^ req_prev_reg;
	assign dst_req_o   = req_data_reg;

	// Destination side answer: read data is caught on the same edge as the toggle flips.
	always_ff @(posedge dst_clk_i) begin
		if (dst_rst_i) begin
			ack_tog_reg <= 1'b0;
			rdata_reg   <= '0;
		end else if (dst_done_i) begin
			ack_tog_reg <= ~ack_tog_reg;
			rdata_reg   <= dst_rdata_i;
		end
	end

endmodule // i2cs_hs_sync

// file: verification/i2cs_assertions.sv
// Concurrent checks on the pins of the two-wire register slave port.
`timescale 1ns/1ps
module i2cs_assertions (
	input wire logic       clock_i,
	input wire logic       srst_i,
	input wire logic       link_clk_i,
	input wire logic       scl_i,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_o,
	input wire logic       reg_wr_o,
	input wire logic       reg_rd_o,
	input wire logic [7:0] reg_addr_o,
	input wire logic [7:0] reg_wdata_o,
	input wire logic [7:0] reg_rdata_i
);
	// Pin side: the device may only pull low, and may only change its drive while the clock is low.
	property p_sda_low_only;
		@(posedge link_clk_i) disable iff (srst_i) sda_o == 1'b0;
	endproperty
	a_sda_low_only: assert property (p_sda_low_only) else $error("sda_o not low");
	property p_oe_edge;
		@(posedge link_clk_i) disable iff (srst_i) $changed(sda_oe_o) |-> !scl_i;
	endproperty
	a_oe_edge: assert property (p_oe_edge) else $error("sda drive moved, scl high");
	// A pull lasts far longer than the sync delay, so eight cycles is a safe floor.
	property p_oe_hold;
		@(posedge link_clk_i) disable iff (srst_i) $rose(sda_oe_o) |-> sda_oe_o [*8];
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("sda pull too short");
	// Core side: one-cycle strobes with fields that move only with them.
	property p_wr_pulse;
		@(posedge clock_i) disable iff (srst_i) reg_wr_o |=> !reg_wr_o;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
	property p_rd_pulse;
		@(posedge clock_i) disable iff (srst_i) reg_rd_o |=> !reg_rd_o;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
	property p_one_dir;
		@(posedge clock_i) disable iff (srst_i) !(reg_wr_o && reg_rd_o);
	endproperty
	a_one_dir: assert property (p_one_dir) else $error("read and write together");
	property p_addr_hold;
		@(posedge clock_i) disable iff (srst_i) $changed(reg_addr_o) |-> (reg_wr_o || reg_rd_o);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved alone");
	property p_wdata_hold;
		@(posedge clock_i) disable iff (srst_i) $changed(reg_wdata_o) |-> reg_wr_o;
	endproperty
	a_wdata_hold: assert property (p_wdata_hold) else $error("write data moved alone");
	c_write: cover property (@(posedge clock_i) disable iff (srst_i) reg_wr_o);
	c_read: cover property (@(posedge clock_i) disable iff (srst_i) reg_rd_o);
	c_ack: cover property (@(posedge link_clk_i) disable iff (srst_i) $rose(sda_oe_o));
endmodule // i2cs_assertions

bind i2cs_slave_port i2cs_assertions i_i2cs_assertions (
	.clock_i(clock_i), .srst_i(srst_i), .link_clk_i(link_clk_i), .scl_i(scl_i),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .reg_wr_o(reg_wr_o),
	.reg_rd_o(reg_rd_o), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
	.reg_rdata_i(reg_rdata_i)
);

// file: verification/i2cs_host_model.sv
// Bus master model that drives the serial clock and pulls the data line.
`timescale 1ns/1ps
module i2cs_host_model #(
	parameter int Q = 157 // Quarter bit in core cycles: 628 cycles a bit, under 400kHz.
) (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_oe_o
);
	// Both lines rest released until the first frame.
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	task automatic qwait;
		repeat (Q) @(posedge clk_i);
	endtask
	// Data falls while the clock is high: also serves as repeated start.
	task automatic start;
		sda_oe_o <= 1'b0;
		qwait();
		scl_o <= 1'b1;
		qwait();
		sda_oe_o <= 1'b1;
		qwait();
		scl_o <= 1'b0;
		qwait();
	endtask
	// Data rises while the clock is high, then the bus rests.
	task automatic stop;
		sda_oe_o <= 1'b1;
		qwait();
		scl_o <= 1'b1;
		qwait();
		sda_oe_o <= 1'b0;
		qwait();
		qwait();
	endtask
	// Data is set in the low phase and held over the high phase.
	task automatic bit_x(input logic b, output logic s);
		sda_oe_o <= ~b;
		qwait();
		scl_o <= 1'b1;
		qwait();
		s = sda_i;
		qwait();
		scl_o <= 1'b0;
		qwait();
	endtask
	// Eight bits most significant first, then the slave's acknowledge.
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], s);
		end
		bit_x(1'b1, ack);
	endtask
	// Eight bits from the slave; low acknowledge asks for more, high ends it.
	task automatic rbyte(input logic ack_bit, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, d[i]);
		end
		bit_x(ack_bit, s);
	endtask
endmodule // i2cs_host_model

// file: verification/tb.sv
// Self-checking bench for the two-wire register slave port.
`timescale 1ns/1ps
module tb;
	logic       clock_i = 1'b0;
	logic       link_clk = 1'b0;
	logic       srst_i = 1'b1;
	logic       scl;
	logic       host_oe;
	logic       dev_oe;
	logic       dev_out;
	logic       sda_w;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] rdata;
	logic [7:0] regs [256];
	int         fails = 0;
	int         checked = 0;
	int         wr_cnt = 0;
	int         rd_cnt = 0;

	always #2 clock_i = ~clock_i;
	// Link clock offset so its edges never line up with the core clock.
	initial begin
		#1.7;
		forever #6 link_clk = ~link_clk;
	end
	// Open-drain wire with pull-up; the core register file answers reads at once.
	assign sda_w = (dev_oe ? dev_out : 1'b1) & ~host_oe;
	assign rdata = regs[reg_addr];
	// Register file updated and strobes counted in the core domain.
	always @(posedge clock_i) begin
		if (reg_wr === 1'b1) begin
			regs[reg_addr] <= reg_wdata;
			wr_cnt <= wr_cnt + 1;
		end
		if (reg_rd === 1'b1) begin
			rd_cnt <= rd_cnt + 1;
		end
	end

	i2cs_slave_port i_i2cs_slave_port (
		.clock_i(clock_i), .srst_i(srst_i), .link_clk_i(link_clk), .scl_i(scl),
		.sda_i(sda_w), .sda_o(dev_out), .sda_oe_o(dev_oe), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
		.reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_rdata_i(rdata)
	);
	i2cs_host_model i_i2cs_host_model (
		.clk_i(clock_i), .sda_i(sda_w), .scl_o(scl), .sda_oe_o(host_oe)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic idle_check;
		check({6'h00, dev_oe, sda_w}, 8'h01);
	endtask
	task automatic burst_write;
		logic a;
		i_i2cs_host_model.start();
		i_i2cs_host_model.wbyte(8'h2A, a);
		check({7'h00, a}, 8'h00);
		i_i2cs_host_model.wbyte(8'h0B, a);
		check({7'h00, a}, 8'h00);
		i_i2cs_host_model.wbyte(8'hA5, a);
		check({7'h00, a}, 8'h00);
		i_i2cs_host_model.wbyte(8'h3C, a);
		check({7'h00, a}, 8'h00);
		i_i2cs_host_model.stop();
		check(regs[8'h0B], 8'hA5);
		check(regs[8'h0C], 8'h3C);
		check(8'(wr_cnt), 8'h02);
		idle_check();
	endtask
	task automatic burst_read;
		logic       a;
		logic [7:0] d;
		i_i2cs_host_model.start();
		i_i2cs_host_model.wbyte(8'h2A, a);
		i_i2cs_host_model.wbyte(8'h0B, a);
		check({7'h00, a}, 8'h00);
		i_i2cs_host_model.start();
		i_i2cs_host_model.wbyte(8'h2B, a);
		check({7'h00, a}, 8'h00);
		i_i2cs_host_model.rbyte(1'b0, d);
		check(d, 8'hA5);
		i_i2cs_host_model.rbyte(1'b1, d);
		check(d, 8'h3C);
		i_i2cs_host_model.stop();
		check(8'(rd_cnt), 8'h02);
		idle_check();
	endtask
	// A foreign address, then an absent register, followed by data that must be ignored.
	task automatic refusals;
		logic a;
		i_i2cs_host_model.start();
		i_i2cs_host_model.wbyte(8'h2C, a);
		check({7'h00, a}, 8'h01);
		i_i2cs_host_model.wbyte(8'h0B, a);
		check({7'h00, a}, 8'h01);
		i_i2cs_host_model.start();
		i_i2cs_host_model.wbyte(8'h2A, a);
		check({7'h00, a}, 8'h00);
		i_i2cs_host_model.wbyte(8'h0D, a);
		check({7'h00, a}, 8'h01);
		i_i2cs_host_model.wbyte(8'h55, a);
		check({7'h00, a}, 8'h01);
		i_i2cs_host_model.stop();
		check(8'(wr_cnt), 8'h02);
		idle_check();
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Main sequence: reset, quiet settle, then each transfer kind.
	initial begin
		for (int i = 0; i < 256; i++) begin
			regs[i] = 8'h00;
		end
		repeat (12) @(posedge clock_i);
		check({dev_oe, reg_wr, reg_rd, 5'h00}, 8'h00);
		check(reg_addr | reg_wdata, 8'h00);
		srst_i <= 1'b0;
		repeat (40) @(posedge clock_i);
		idle_check();
		burst_write();
		burst_read();
		refusals();
		complete_run();
	end
endmodule // tb
